/* shared/scpm_pkg.sv */
package scpm_pkg;
   // register offsets
   localparam logic [2:0] OFS_COUNT_B0     = 3'h0;
   localparam logic [2:0] OFS_COUNT_B3     = 3'h3;
   localparam logic [2:0] OFS_OSC_CTRL     = 3'h4;
   localparam logic [2:0] OFS_CHARGE_CFG   = 3'h5;
   localparam logic [2:0] OFS_LAST         = 3'h5;
   // field positions
   localparam int         OSC_DIS_BIT      = 7;
   localparam int         KEY_MSB          = 7;
   localparam int         KEY_LSB          = 4;
   localparam int         DIODE_MSB        = 3;
   localparam int         DIODE_LSB        = 2;
   localparam int         RES_MSB          = 1;
   localparam int         RES_LSB          = 0;
   // field codes
   localparam logic [3:0] CHARGE_KEY_ON    = 4'ha;
   localparam logic [1:0] DIODE_NONE       = 2'h1;
   localparam logic [1:0] DIODE_ONE        = 2'h2;
   localparam logic [1:0] RES_OFF          = 2'h0;
   // reset values
   localparam logic [31:0] COUNT_RST       = 32'h0000_0000;
   localparam logic        OSC_DIS_RST     = 1'h0;
   localparam logic [7:0]  CHARGE_CFG_RST  = 8'h00;
   // serial bus address, read bit set in lsb
   localparam logic [6:0] DEV_ADDR         = 7'h68;
   // timebase figures
   localparam int         XTAL_HZ          = 32768;
   localparam int         HOLD_MS          = 250;
   localparam int         OSC_START_MS     = 1000;
   localparam int         HOLD_TICKS       = XTAL_HZ * HOLD_MS / 1000;
   localparam int         OSC_START_TICKS  = XTAL_HZ * OSC_START_MS / 1000;
endpackage : scpm_pkg

/* verilog/scpm_twi_slave.sv */
`timescale 1ns/1ns
// byte engine of the two-wire slave; works on cleaned scl/sda levels
module scpm_twi_slave (
   input  wire logic       sys_clk,
   input  wire logic       rst_sync_n,
   input  wire logic       scl,
   input  wire logic       sda,
   input  wire logic       bus_enable,
   input  wire logic [7:0] tx_byte,
   output logic            sda_oe,
   output logic [7:0]      rx_byte,
   output logic            ptr_load,
   output logic            data_wr,
   output logic            rd_done
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WDATA, ST_WACK, ST_RDATA, ST_RACK
   } scpm_twi_state_t;

   scpm_twi_state_t state;        // bus phase
   logic [7:0]      shreg;        // shift register
   logic [3:0]      bit_cnt;      // bits moved in this byte
   logic            is_read;      // direction of this access
   logic            first;        // next written byte is the offset
   logic            scl_d;        // previous scl
   logic            sda_d;        // previous sda
   logic            start_cond;   // sda falls while scl high
   logic            stop_cond;    // sda rises while scl high
   logic            scl_rise;
   logic            scl_fall;

   // line conditions
   assign start_cond = scl & scl_d & sda_d & ~sda;
   assign stop_cond  = scl & scl_d & ~sda_d & sda;
   assign scl_rise   = scl & ~scl_d;
   assign scl_fall   = ~scl & scl_d;

   // previous levels
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl;
         sda_d <= sda;
      end
   end

   // protocol state machine
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state    <= ST_IDLE;
         shreg    <= 8'h00;
         bit_cnt  <= 4'h0;
         is_read  <= 1'b0;
         first    <= 1'b0;
         sda_oe   <= 1'b0;
         rx_byte  <= 8'h00;
         ptr_load <= 1'b0;
         data_wr  <= 1'b0;
         rd_done  <= 1'b0;
      end else begin
         ptr_load <= 1'b0;
         data_wr  <= 1'b0;
         rd_done  <= 1'b0;
         if (!bus_enable) begin
            // supply low: deaf to the bus
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
         end else if (start_cond) begin
            // start or repeated start opens an access
            state   <= ST_ADDR;
            bit_cnt <= 4'h0;
            first   <= 1'b1;
            sda_oe  <= 1'b0;
         end else if (stop_cond) begin
            state  <= ST_IDLE;
            sda_oe <= 1'b0;
         end else if (scl_rise) begin
            unique case (state)
               ST_ADDR, ST_WDATA: begin
                  shreg   <= {shreg[6:0], sda};
                  bit_cnt <= bit_cnt + 4'h1;
               end
               ST_RACK: begin
                  // master nack ends the read burst
                  if (sda) begin
                     state <= ST_IDLE;
                  end
               end
               default: ;
            endcase
         end else if (scl_fall) begin
            unique case (state)
               ST_ADDR: begin
                  if (bit_cnt == 4'h8) begin
                     if (shreg[7:1] == scpm_pkg::DEV_ADDR) begin
                        state   <= ST_ADDR_ACK;
                        sda_oe  <= 1'b1;
                        is_read <= shreg[0];
                     end else begin
                        state <= ST_IDLE;
                     end
                  end
               end
               ST_ADDR_ACK: begin
                  if (is_read) begin
                     state   <= ST_RDATA;
                     shreg   <= tx_byte;
                     sda_oe  <= ~tx_byte[7];
                     bit_cnt <= 4'h1;
                  end else begin
                     state   <= ST_WDATA;
                     sda_oe  <= 1'b0;
                     bit_cnt <= 4'h0;
                  end
               end
               ST_WDATA: begin
                  if (bit_cnt == 4'h8) begin
                     // acknowledge and hand the byte over
                     state    <= ST_WACK;
                     sda_oe   <= 1'b1;
                     rx_byte  <= shreg;
                     ptr_load <= first;
                     data_wr  <= ~first;
                     first    <= 1'b0;
                  end
               end
               ST_WACK: begin
                  state   <= ST_WDATA;
                  sda_oe  <= 1'b0;
                  bit_cnt <= 4'h0;
               end
               ST_RDATA: begin
                  if (bit_cnt == 4'h8) begin
                     state   <= ST_RACK;
                     sda_oe  <= 1'b0;
                     rd_done <= 1'b1;
                  end else begin
                     sda_oe  <= ~shreg[6];
                     shreg   <= {shreg[6:0], 1'b0};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
               ST_RACK: begin
                  // master acked: send next register
                  state   <= ST_RDATA;
                  shreg   <= tx_byte;
                  sda_oe  <= ~tx_byte[7];
                  bit_cnt <= 4'h1;
               end
               default: ;
            endcase
         end
      end
   end
endmodule : scpm_twi_slave

/* verilog/scpm_top.sv */
`timescale 1ns/1ns
// Notes on behaviour
// - 32-bit count, bytes 0..3, lsb first
// - pointer increments per byte, wraps 5 to 0
// - access: start, address, offset, burst, stop
// - offset 4 bit 7 is oscillator disable
// - backup: disable bit stops oscillator, standby
// - main power: oscillator runs, counting gated
// - count once per second from timebase
// - crystal or external clock on input
// - power fail blocks all register access
// - power fail drives reset low immediately
// - reset held 250ms after power returns
// - disabled oscillator adds start-up to hold
// - offset 5: key, diode, resistor fields
// - charger on only for key 1010
// - first written byte loads the pointer
module scpm_top #(
   parameter int TICKS_PER_SEC = scpm_pkg::XTAL_HZ,
   parameter int HOLD_TICKS    = scpm_pkg::HOLD_TICKS,
   parameter int START_TICKS   = scpm_pkg::OSC_START_TICKS
) (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   output logic            sda_out,
   output logic            sda_oe,
   input  wire logic       crystal_in,
   output logic            crystal_out,
   input  wire logic       power_good,
   output logic            rst_out_n,
   output logic            rst_out_n_oe,
   output logic            osc_standby,
   output logic            charge_enable,
   output logic [1:0]      diode_select,
   output logic [1:0]      resistor_select
);
   localparam int PRE_W  = $clog2(TICKS_PER_SEC);
   localparam int HOLD_W = $clog2(HOLD_TICKS + START_TICKS + 1);

   logic [1:0]       rst_pipe;       // reset release pipe
   logic             rst_sync_n;     // released reset
   logic [3:0]       raw_in;         // pins to clean
   logic [3:0]       sy1, sy2, sy3;  // sync stages
   logic [3:0]       clean;          // agreed levels
   logic             pwr_ok;         // main supply above threshold
   logic             pwr_ok_d;       // previous pwr_ok
   logic             xtal_d;         // previous timebase level
   logic             xtal_edge;      // timebase rising edge
   logic             osc_run;        // oscillator running
   logic [PRE_W-1:0] prescale;       // timebase edges this second
   logic             sec_inc;        // one second elapsed, counting
   logic [31:0]      count;          // seconds count
   logic [31:0]      next_count;
   logic             osc_disable_n;  // oscillator disable, active high
   logic [7:0]       charge_cfg;     // charger configuration byte
   logic [2:0]       ptr;            // register pointer
   logic [7:0]       tx_byte;        // byte at pointer
   logic [7:0]       rx_byte;        // byte from master
   logic             ptr_load;
   logic             data_wr;
   logic             rd_done;
   logic             reg_wr;         // gated register write
   logic             rst_act;        // reset output active
   logic [HOLD_W-1:0] hold;          // hold ticks remaining
   logic             slave_oe;

   // reset release through two flops
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_pipe <= 2'b00;
      end else begin
         rst_pipe <= {rst_pipe[0], 1'b1};
      end
   end
   assign rst_sync_n = rst_pipe[1];

   // three-stage cleaning of outside pins
   assign raw_in = {power_good, crystal_in, sda_in, scl_in};
   for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_sync_n) begin
         if (!rst_sync_n) begin
            // bus lines start at their idle high level, supply starts failed
            sy1[i]   <= (i < 2) ? 1'b1 : 1'b0;
            sy2[i]   <= (i < 2) ? 1'b1 : 1'b0;
            sy3[i]   <= (i < 2) ? 1'b1 : 1'b0;
            clean[i] <= (i < 2) ? 1'b1 : 1'b0;
         end else begin
            sy1[i] <= raw_in[i];
            sy2[i] <= sy1[i];
            sy3[i] <= sy2[i];
            if (sy2[i] == sy3[i]) begin
               clean[i] <= sy3[i];
            end
         end
      end
   end
   assign pwr_ok  = clean[3];
   assign osc_run = pwr_ok | ~osc_disable_n;
   assign xtal_edge = osc_run & clean[2] & ~xtal_d;
   assign reg_wr  = data_wr & pwr_ok;

   // two-wire byte engine
   scpm_twi_slave u_slave (
      .sys_clk    (sys_clk),
      .rst_sync_n (rst_sync_n),
      .scl        (clean[0]),
      .sda        (clean[1]),
      .bus_enable (pwr_ok),
      .tx_byte    (tx_byte),
      .sda_oe     (slave_oe),
      .rx_byte    (rx_byte),
      .ptr_load   (ptr_load),
      .data_wr    (data_wr),
      .rd_done    (rd_done)
   );
   assign sda_oe  = slave_oe;

   // read mux, undefined bits read zero
   always_comb begin
      case (ptr)
         3'h0, 3'h1, 3'h2, 3'h3: tx_byte = count[{ptr[1:0], 3'b000} +: 8];
         scpm_pkg::OFS_OSC_CTRL:   tx_byte = {osc_disable_n, 7'h00};
         scpm_pkg::OFS_CHARGE_CFG: tx_byte = charge_cfg;
         default:                  tx_byte = 8'h00;
      endcase
   end

   // pointer load and auto increment with wrap
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         ptr <= scpm_pkg::OFS_COUNT_B0;
      end else if (!pwr_ok) begin
         ptr <= ptr;
      end else if (ptr_load) begin
         ptr <= rx_byte[2:0];
      end else if (data_wr || rd_done) begin
         ptr <= (ptr >= scpm_pkg::OFS_LAST) ? scpm_pkg::OFS_COUNT_B0 : ptr + 3'h1;
      end
   end

   // timebase edge and one-second prescaler
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         xtal_d   <= 1'b0;
         prescale <= '0;
         sec_inc  <= 1'b0;
      end else begin
         xtal_d  <= clean[2];
         sec_inc <= 1'b0;
         if (xtal_edge) begin
            if (prescale == PRE_W'(TICKS_PER_SEC - 1)) begin
               prescale <= '0;
               sec_inc  <= ~osc_disable_n;
            end else begin
               prescale <= prescale + PRE_W'(1);
            end
         end
      end
   end

   // next count: increment, then written byte replaces its lane
   always_comb begin
      next_count = count + {31'h0, sec_inc};
      if (reg_wr && ptr <= scpm_pkg::OFS_COUNT_B3) begin
         next_count[{ptr[1:0], 3'b000} +: 8] = rx_byte;
      end
   end

   // seconds count
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         count <= scpm_pkg::COUNT_RST;
      end else begin
         count <= next_count;
      end
   end

   // control and charger registers
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         osc_disable_n <= scpm_pkg::OSC_DIS_RST;
         charge_cfg    <= scpm_pkg::CHARGE_CFG_RST;
      end else if (reg_wr) begin
         if (ptr == scpm_pkg::OFS_OSC_CTRL) begin
            osc_disable_n <= rx_byte[scpm_pkg::OSC_DIS_BIT];
         end
         if (ptr == scpm_pkg::OFS_CHARGE_CFG) begin
            charge_cfg <= rx_byte;
         end
      end
   end

   // processor reset: asserted on fail, hold counted on timebase
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rst_act  <= 1'b1;
         pwr_ok_d <= 1'b0;
         hold     <= '0;
      end else begin
         pwr_ok_d <= pwr_ok;
         if (!pwr_ok) begin
            rst_act <= 1'b1;
            hold    <= '0;
         end else if (!pwr_ok_d) begin
            hold <= osc_disable_n ? HOLD_W'(HOLD_TICKS + START_TICKS)
                                  : HOLD_W'(HOLD_TICKS);
         end else if (rst_act && xtal_edge) begin
            hold <= hold - HOLD_W'(1);
            if (hold <= HOLD_W'(1)) begin
               rst_act <= 1'b0;
            end
         end
      end
   end

   // pin and charger outputs, all registered
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         rst_out_n       <= 1'b0;
         rst_out_n_oe    <= 1'b1;
         sda_out         <= 1'b0;
         osc_standby     <= 1'b0;
         crystal_out     <= 1'b0;
         charge_enable   <= 1'b0;
         diode_select    <= 2'h0;
         resistor_select <= 2'h0;
      end else begin
         rst_out_n       <= 1'b0;                                  // open drain, only pulls low
         sda_out         <= 1'b0;                                  // open drain, only pulls low
         rst_out_n_oe    <= rst_act;
         osc_standby     <= ~pwr_ok & osc_disable_n;
         crystal_out     <= osc_run & ~clean[2];
         diode_select    <= charge_cfg[scpm_pkg::DIODE_MSB:scpm_pkg::DIODE_LSB];
         resistor_select <= charge_cfg[scpm_pkg::RES_MSB:scpm_pkg::RES_LSB];
         charge_enable   <= (charge_cfg[scpm_pkg::KEY_MSB:scpm_pkg::KEY_LSB] == scpm_pkg::CHARGE_KEY_ON)
                            && (charge_cfg[3:2] == scpm_pkg::DIODE_NONE || charge_cfg[3:2] == scpm_pkg::DIODE_ONE)
                            && (charge_cfg[1:0] != scpm_pkg::RES_OFF);
      end
   end

   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_sync_n);

   a_ptr_wrap: assert property ((data_wr || rd_done) && pwr_ok && !ptr_load && ptr == 3'h5 |=> ptr == 3'h0)
      else $error("pointer did not wrap to zero");
   a_ptr_load_val: assert property (ptr_load && pwr_ok |=> ptr == $past(rx_byte[2:0]))
      else $error("pointer not loaded from first byte");
   a_count_step: assert property (sec_inc && !reg_wr |=> count == $past(count) + 32'h1)
      else $error("count did not advance on second");
   a_count_gated: assert property (osc_disable_n && $past(osc_disable_n) && !reg_wr |=> $stable(count))
      else $error("count moved while disabled");
   a_byte_lane: assert property (reg_wr && ptr == 3'h0 && !sec_inc |=> count[7:0] == $past(rx_byte)
                                 && count[31:8] == $past(count[31:8]))
      else $error("byte write disturbed other lanes");
   a_bus_blocked: assert property (!pwr_ok |=> !slave_oe && $stable(ptr) && $stable(charge_cfg))
      else $error("register access during power fail");
   a_rst_on_fail: assert property (!pwr_ok |-> ##2 rst_out_n_oe)
      else $error("reset not driven on power fail");
   a_rst_hold: assert property ($rose(pwr_ok) |-> ##2 rst_out_n_oe [*8])
      else $error("reset released too early");
   a_standby: assert property (!pwr_ok && osc_disable_n |=> osc_standby && !crystal_out && $stable(prescale))
      else $error("oscillator not stopped in standby");
   a_charge_key: assert property (charge_enable |-> $past(charge_cfg[7:4]) == 4'ha)
      else $error("charger on without key");
endmodule : scpm_top

/* test/scpm_bus_master.sv */
`timescale 1ns/1ns
// two-wire bus master model; open drain, so it only ever pulls sda low
module scpm_bus_master #(
   parameter int HALF = 15
) (
   input  wire logic clk,
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda_line
);
   // idle bus: both lines released to the pull-ups
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end
   // half a bus clock period, well above the input cleaning delay
   task automatic tick();
      repeat (HALF) @(posedge clk);
   endtask : tick
   // start or repeated start: sda falls while scl is high
   task automatic start();
      sda_low <= 1'b0;
      tick();
      scl <= 1'b1;
      tick();
      sda_low <= 1'b1;
      tick();
      scl <= 1'b0;
      tick();
   endtask : start
   // stop: sda rises while scl is high
   task automatic stop();
      sda_low <= 1'b1;
      tick();
      scl <= 1'b1;
      tick();
      sda_low <= 1'b0;
      tick();
   endtask : stop
   // one bit: data changed while scl low, line sampled at end of scl high
   task automatic bit_io(input logic b, output logic r);
      sda_low <= ~b;
      tick();
      scl <= 1'b1;
      tick();
      r = sda_line;
      scl <= 1'b0;
      // sda moves one cycle after the scl fall, never with it
      @(posedge clk);
   endtask : bit_io
   // byte out msb first, then the ninth clock for the slave's ack
   task automatic send_byte(input logic [7:0] b, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(b[i], r);
      bit_io(1'b1, r);
      ack = ~r;
   endtask : send_byte
   // byte in msb first; last byte answered with a nack
   task automatic recv_byte(input logic last, output logic [7:0] b);
      logic r;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
      bit_io(last, r);
   endtask : recv_byte
endmodule : scpm_bus_master

/* test/scpm_top_tb.sv */
`timescale 1ns/1ns
// self-checking bench for the seconds counter with power monitor
module scpm_top_tb;
   logic        sys_clk;           // 25 MHz system clock
   logic        rst_n;             // bench reset
   logic        crystal_in;        // 320 ns timebase
   logic        power_good;        // main supply state
   logic        scl, m_sda_low;    // master pins
   logic        sda_out, sda_oe;   // device sda drive
   logic        rst_out_n, rst_out_n_oe, crystal_out, osc_standby, charge_enable;
   logic [1:0]  diode_select, resistor_select;
   logic        bus_ok;            // every byte of the last write acked
   logic [7:0]  rq[$];             // bytes of the last read
   int          num_errors, num_checks, cyc, stamp;
   // open-drain lines with pull-ups
   wire         sda_line = ~(m_sda_low | (sda_oe & ~sda_out));
   wire         rst_pin  = rst_out_n_oe ? rst_out_n : 1'b1;

   scpm_top #(.TICKS_PER_SEC(64), .HOLD_TICKS(4), .START_TICKS(4)) DUT (
      .sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .crystal_in(crystal_in), .crystal_out(crystal_out), .power_good(power_good),
      .rst_out_n(rst_out_n), .rst_out_n_oe(rst_out_n_oe), .osc_standby(osc_standby),
      .charge_enable(charge_enable), .diode_select(diode_select), .resistor_select(resistor_select));
   scpm_bus_master MST (.clk(sys_clk), .scl(scl), .sda_low(m_sda_low), .sda_line(sda_line));

   // clocks: timebase free running, unrelated in phase
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   initial begin
      crystal_in = 1'b0;
      #7;
      forever #160 crystal_in = ~crystal_in;
   end
   // cycle stamp for elapsed-time figures
   always @(posedge sys_clk) cyc <= cyc + 1;

   // one comparison, counted
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // compare the last read against a list
   task automatic chkq(input logic [7:0] e[$]);
      foreach (e[i]) chk(rq[i], e[i]);
   endtask : chkq
   // write burst from an offset
   task automatic wr(input logic [2:0] ofs, input logic [7:0] d[$]);
      logic a;
      MST.start();
      MST.send_byte({scpm_pkg::DEV_ADDR, 1'b0}, bus_ok);
      MST.send_byte({5'h00, ofs}, a);
      bus_ok &= a;
      foreach (d[i]) begin
         MST.send_byte(d[i], a);
         bus_ok &= a;
      end
      MST.stop();
      stamp = cyc;
   endtask : wr
   // set pointer, repeated start, read n bytes
   task automatic rd(input logic [2:0] ofs, input int n);
      logic       a;
      logic [7:0] b;
      rq = {};
      MST.start();
      MST.send_byte({scpm_pkg::DEV_ADDR, 1'b0}, a);
      MST.send_byte({5'h00, ofs}, a);
      MST.start();
      MST.send_byte({scpm_pkg::DEV_ADDR, 1'b1}, a);
      for (int i = 0; i < n; i++) begin
         MST.recv_byte(i == n - 1, b);
         rq.push_back(b);
      end
      MST.stop();
   endtask : rd

   // reset values and first release of the reset pin
   task automatic t_reset();
      logic seen;
      seen = 1'b0;
      chk(rst_pin, 1'b0);
      for (int i = 0; i < 400 && rst_pin !== 1'b1; i++) @(posedge sys_clk);
      chk(rst_pin, 1'b1);
      rd(3'h4, 2);
      chkq('{8'h00, 8'h00});
      chk(charge_enable, 1'b0);
      // running oscillator must show its output swinging
      repeat (16) begin
         @(posedge sys_clk);
         seen |= crystal_out;
      end
      chk(seen, 1'b1);
   endtask : t_reset
   // burst with wrap, read-only control bits, single byte lane, charger codes
   task automatic t_burst();
      logic [7:0] cfg[5] = '{8'ha5, 8'h95, 8'had, 8'ha4, 8'hab};
      logic [4:0] exp[5] = '{5'b1_01_01, 5'b0_01_01, 5'b0_11_01, 5'b0_01_00, 5'b1_10_11};
      wr(3'h4, '{8'h80});
      wr(3'h0, '{8'h11, 8'h22, 8'h33, 8'h44, 8'hff, 8'ha5, 8'h55});
      chk(bus_ok, 1'b1);
      rd(3'h0, 7);
      chkq('{8'h55, 8'h22, 8'h33, 8'h44, 8'h80, 8'ha5, 8'h55});
      wr(3'h2, '{8'h77});
      rd(3'h0, 4);
      chkq('{8'h55, 8'h22, 8'h77, 8'h44});
      foreach (cfg[i]) begin
         wr(3'h5, '{cfg[i]});
         chk({charge_enable, diode_select, resistor_select}, exp[i]);
      end
   endtask : t_burst
   // foreign address is not acknowledged
   task automatic t_nack();
      logic a;
      MST.start();
      MST.send_byte(8'ha0, a);
      MST.stop();
      chk(a, 1'b0);
   endtask : t_nack
   // seconds rate and roll-over while counting is enabled
   task automatic t_count();
      int         t1, n;
      logic [31:0] d;
      wr(3'h0, '{8'hfe, 8'hff, 8'hff, 8'hff});
      wr(3'h4, '{8'h00});
      t1 = stamp;
      repeat (2000) @(posedge sys_clk);
      wr(3'h4, '{8'h80});
      n = (stamp - t1) / 512;
      rd(3'h0, 4);
      d = {rq[3], rq[2], rq[1], rq[0]} - 32'hffff_fffe;
      num_checks++;
      if ((d + 1 >= n && d <= n + 1) !== 1'b1) begin
         num_errors++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, d, n);
      end
   endtask : t_count
   // power fail with oscillator stopped, then with it running
   task automatic t_power();
      power_good <= 1'b0;
      repeat (8) @(posedge sys_clk);
      chk(rst_pin, 1'b0);
      repeat (10) @(posedge sys_clk);
      chk(osc_standby, 1'b1);
      chk(crystal_out, 1'b0);
      wr(3'h5, '{8'h00});
      chk(bus_ok, 1'b0);
      power_good <= 1'b1;
      repeat (40) @(posedge sys_clk);
      chk(rst_pin, 1'b0);
      repeat (60) @(posedge sys_clk);
      chk(rst_pin, 1'b1);
      chk(osc_standby, 1'b0);
      rd(3'h5, 1);
      chkq('{8'hab});
      wr(3'h4, '{8'h00});
      power_good <= 1'b0;
      repeat (20) @(posedge sys_clk);
      chk(osc_standby, 1'b0);
      power_good <= 1'b1;
      repeat (16) @(posedge sys_clk);
      chk(rst_pin, 1'b0);
      repeat (44) @(posedge sys_clk);
      chk(rst_pin, 1'b1);
   endtask : t_power

   // verdict and end of run
   task automatic wrap_up();
      if (num_errors == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : wrap_up

   // main sequence
   initial begin
      rst_n      = 1'b0;
      power_good = 1'b1;
      num_errors = 0;
      num_checks = 0;
      cyc        = 0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_reset();
      t_burst();
      t_nack();
      t_count();
      t_power();
      wrap_up();
   end
   // hang guard, about three times the expected run
   initial begin
      #3_000_000;
      num_errors++;
      wrap_up();
   end
endmodule : scpm_top_tb
